/* iqlp_pkg.sv */
// Constants and types for the input qualifier and low-power wake block.
// Assumes one 20 MHz system clock; timing figures below, except CLK_NS in ns, are in its cycles.
package iqlp_pkg;
    // Pin grouping
    localparam int          PINS          = 16;
    localparam int          GROUP         = 8;
    localparam int          NGRP          = PINS / GROUP;
    localparam int          SYNC_W        = PINS + 3;
    // Clock
    localparam int          CLK_NS        = 50;
    // Qualifier sample depths
    localparam logic [2:0]  SAMPLES3      = 3'h3;
    localparam logic [2:0]  SAMPLES6      = 3'h6;
    // Resume latencies in system clock cycles
    localparam logic [10:0] IDLE_RES      = 11'h014;
    localparam logic [10:0] IDLE_RES_SLP  = 11'h41a;
    localparam logic [10:0] SB_RES        = 11'h064;
    localparam logic [10:0] SB_RES_SLP    = 11'h465;
    // Standby entry timing
    localparam logic [10:0] XCLK_LOW      = 11'h020;
    localparam logic [10:0] HOLD_LO       = 11'h010;
    localparam logic [10:0] HOLD_10       = 11'h020;
    localparam logic [10:0] HOLD_11       = 11'h040;
    // Standby wake pulse widths
    localparam logic [6:0]  SB_UNQ        = 7'h03;
    localparam logic [6:0]  SB_QBASE      = 7'h02;
    // Reset values
    localparam logic        QUAL_RST      = 1'b1;
    localparam logic [5:0]  SMP_RST       = 6'h3f;

    typedef enum logic [2:0] {
        LP_RUN, LP_IDLE, LP_SB_HOLD, LP_SB_SLEEP, LP_RESUME
    } iqlp_state_t;
endpackage

/* iqlp_src_model.sv */
// Behavioural model of the asynchronous sources that drive the block's pins.
// Assumes the bench calls its tasks; every change lands just after a rising edge.
module iqlp_src_model (
    // Clock used only to time the pulses
    input  wire logic        sys_clk_in,
    // Pin and wake lines towards the block
    output logic      [15:0] pin_out,
    output logic             nmi_out,
    output logic             rst_pin_n_out,
    output logic             stby_wake_n_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle levels: pins and active-low lines rest high
    initial begin
        pin_out         = 16'hffff;
        nmi_out         = 1'b0;
        rst_pin_n_out   = 1'b1;
        stby_wake_n_out = 1'b1;
    end

    // Hold one pin at a level until told otherwise
    task automatic pin_set(input int idx, input logic lvl);
        @(posedge sys_clk_in);
        pin_out[idx] <= lvl;
    endtask

    // Low pulse of a given width on one pin
    task automatic pin_pulse(input int idx, input int w);
        pin_set(idx, 1'b0);
        repeat (w) @(posedge sys_clk_in);
        pin_out[idx] <= 1'b1;
    endtask

    // Level wake lines, held until released by the bench
    task automatic wake_set(input int which, input logic act);
        if (which == 2) nmi_out <= act;
        if (which == 3) rst_pin_n_out <= !act;
    endtask

    // Low pulse on the standby wake line
    task automatic wake_pulse(input int w);
        @(posedge sys_clk_in);
        stby_wake_n_out <= 1'b0;
        repeat (w) @(posedge sys_clk_in);
        stby_wake_n_out <= 1'b1;
    endtask
endmodule

/* iqlp_tb_top.sv */
// Self-checking bench for the input qualifier and low-power wake block.
// Assumes the source model drives async pins; the bench drives the rest.
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module iqlp_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // Stimulus and observed signals
    logic        sys_clk_in, rst_n_in, idle_exec_in, lpm_standby_in, flash_sleep_in;
    logic        wake_irq_in, watchdog_interrupt_in, ext_nonmaskable_irq_in;
    logic        device_reset_pin_n_in, standby_wake_n_in;
    logic [15:0] pin_in, qual_period_field_in, qual_select_reg_in, pin_qual_out;
    logic [1:0]  clock_divide_select_in;
    logic [5:0]  standby_qual_count_in;
    logic        sys_clk_en_out, periph_clk_en_out, pll_wd_run_out, external_clock_out;
    logic        resume_out, service_irq_out, low_power_out;
    int          err_count, tests_run;
    logic [31:0] seed;

    iqlp_top i_iqlp_top (
        .sys_clk_in             (sys_clk_in),
        .rst_n_in               (rst_n_in),
        .pin_in                 (pin_in),
        .qual_period_field_in   (qual_period_field_in),
        .qual_select_reg_in     (qual_select_reg_in),
        .pin_qual_out           (pin_qual_out),
        .idle_exec_in           (idle_exec_in),
        .lpm_standby_in         (lpm_standby_in),
        .clock_divide_select_in (clock_divide_select_in),
        .standby_qual_count_in  (standby_qual_count_in),
        .flash_sleep_in         (flash_sleep_in),
        .wake_irq_in            (wake_irq_in),
        .watchdog_interrupt_in  (watchdog_interrupt_in),
        .ext_nonmaskable_irq_in (ext_nonmaskable_irq_in),
        .device_reset_pin_n_in  (device_reset_pin_n_in),
        .standby_wake_n_in      (standby_wake_n_in),
        .sys_clk_en_out         (sys_clk_en_out),
        .periph_clk_en_out      (periph_clk_en_out),
        .pll_wd_run_out         (pll_wd_run_out),
        .external_clock_out     (external_clock_out),
        .resume_out             (resume_out),
        .service_irq_out        (service_irq_out),
        .low_power_out          (low_power_out)
    );
    iqlp_src_model i_iqlp_src_model (.sys_clk_in(sys_clk_in), .pin_out(pin_in),
        .nmi_out(ext_nonmaskable_irq_in), .rst_pin_n_out(device_reset_pin_n_in),
        .stby_wake_n_out(standby_wake_n_in));

    // 20 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // Expectation helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int samp_per(input logic [7:0] per);
        return (per == 8'h00) ? 1 : 2 * int'(per);
    endfunction
    function automatic int lat_of(input logic sb, input logic fs);
        if (sb) return fs ? int'(iqlp_pkg::SB_RES_SLP) : int'(iqlp_pkg::SB_RES);
        return fs ? int'(iqlp_pkg::IDLE_RES_SLP) : int'(iqlp_pkg::IDLE_RES);
    endfunction
    function automatic int hold_of(input logic [1:0] d);
        if (d == 2'h3) return int'(iqlp_pkg::HOLD_11);
        if (d == 2'h2) return int'(iqlp_pkg::HOLD_10);
        return int'(iqlp_pkg::HOLD_LO);
    endfunction

    // Verdict and end of run
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic bound_hit(input int k, input int lim);
        if (k >= lim) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, k, lim);
            complete_run();
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask

    // Glitch rejected, then a stable low is qualified no sooner than its window
    task automatic qual_case(input int idx, input logic sel, input logic [7:0] per);
        int   sp, win, k;
        logic seen;
        sp = samp_per(per);
        win = (sel ? 5 : 2) * sp;
        @(posedge sys_clk_in);
        qual_period_field_in[(idx / 8) * 8 +: 8] <= per;
        qual_select_reg_in[idx] <= sel;
        tick(4);
        i_iqlp_src_model.pin_pulse(idx, win);
        seen = 1'b0;
        repeat (win + 2 * sp + 6) begin
            @(posedge sys_clk_in);
            if (pin_qual_out !== 16'hffff) seen = 1'b1;
        end
        `CHK(seen, 1'b0)
        i_iqlp_src_model.pin_set(idx, 1'b0);
        k = 0;
        while (pin_qual_out[idx] !== 1'b0 && k < win + 2 * sp + 8) begin
            @(posedge sys_clk_in);
            k++;
        end
        bound_hit(k, win + 2 * sp + 8);
        `CHK(k >= win, 1'b1)
        `CHK(pin_qual_out, ~(16'h0001 << idx))
        i_iqlp_src_model.pin_set(idx, 1'b1);
        tick(win + 2 * sp + 8);
        `CHK(pin_qual_out, 16'hffff)
    endtask

    // Wake sources for idle: 0 irq, 1 watchdog, 2 non-maskable, 3 reset pin
    task automatic set_wake(input int src, input logic act);
        @(posedge sys_clk_in);
        if (src == 0) wake_irq_in <= act;
        if (src == 1) watchdog_interrupt_in <= act;
        i_iqlp_src_model.wake_set(src, act);
    endtask
    task automatic lp_idle(input int src);
        int   k, lat;
        logic fs;
        seed = lfsr_next(seed);
        fs = seed[0];
        lat = lat_of(1'b0, fs);
        @(posedge sys_clk_in);
        idle_exec_in <= 1'b1;
        lpm_standby_in <= 1'b0;
        flash_sleep_in <= fs;
        @(posedge sys_clk_in);
        idle_exec_in <= 1'b0;
        tick(5);
        `CHK(low_power_out, 1'b1)
        set_wake(src, 1'b1);
        k = 0;
        while (resume_out !== 1'b1 && k < lat + 8) begin
            @(posedge sys_clk_in);
            k++;
        end
        bound_hit(k, lat + 8);
        `CHK(k <= lat + 1, 1'b1)
        `CHK(service_irq_out, src == 0)
        set_wake(src, 1'b0);
        tick(3);
        `CHK({low_power_out, resume_out}, 2'b00)
    endtask

    // Standby entry, a short pulse refused, then a full pulse wakes
    task automatic lp_stby(input logic [1:0] dsel, input logic irq);
        int         k, lat, need;
        logic       fs;
        logic [5:0] cnt;
        seed = lfsr_next(seed);
        fs = seed[0];
        cnt = seed[8:3];
        need = (cnt == 6'h00) ? int'(iqlp_pkg::SB_UNQ) : int'(iqlp_pkg::SB_QBASE) + int'(cnt);
        lat = lat_of(1'b1, fs);
        @(posedge sys_clk_in);
        idle_exec_in <= 1'b1;
        lpm_standby_in <= 1'b1;
        clock_divide_select_in <= dsel;
        standby_qual_count_in <= cnt;
        flash_sleep_in <= fs;
        @(posedge sys_clk_in);
        idle_exec_in <= 1'b0;
        k = 1;
        while (sys_clk_en_out !== 1'b0 && k < 100) begin
            @(posedge sys_clk_in);
            k++;
        end
        bound_hit(k, 100);
        `CHK(k >= hold_of(dsel) && k <= hold_of(dsel) + 5, 1'b1)
        `CHK({periph_clk_en_out, pll_wd_run_out}, 2'b01)
        if (k < 48) tick(48 - k);
        `CHK(external_clock_out, 1'b0)
        i_iqlp_src_model.wake_pulse(need - 1);
        tick(need + 8);
        `CHK({low_power_out, sys_clk_en_out}, 2'b10)
        @(posedge sys_clk_in);
        wake_irq_in <= irq;
        fork
            i_iqlp_src_model.wake_pulse(need);
        join_none
        k = 0;
        while (resume_out !== 1'b1 && k < lat + need + 8) begin
            @(posedge sys_clk_in);
            k++;
        end
        bound_hit(k, lat + need + 8);
        `CHK(k <= lat + ((cnt == 6'h00) ? 0 : need) + 2, 1'b1)
        `CHK(service_irq_out, irq)
        @(posedge sys_clk_in);
        wake_irq_in <= 1'b0;
        tick(need + 4);
    endtask

    // Main sequence
    initial begin
        {rst_n_in, idle_exec_in, lpm_standby_in, flash_sleep_in} = 4'h0;
        {wake_irq_in, watchdog_interrupt_in} = 2'h0;
        qual_period_field_in = 16'h0000;
        qual_select_reg_in = 16'h0000;
        clock_divide_select_in = 2'h0;
        standby_qual_count_in = 6'h00;
        err_count = 0;
        tests_run = 0;
        seed = 32'h63a795b9;
        tick(19);
        `CHK(pin_qual_out, 16'hffff)
        `CHK({sys_clk_en_out, periph_clk_en_out, pll_wd_run_out, low_power_out}, 4'he)
        @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        tick(4);
        qual_case(0, 1'b0, 8'h00);
        qual_case(9, 1'b1, 8'h00);
        qual_case(15, 1'b1, 8'hff);
        qual_case(2, 1'b0, 8'hff);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            @(posedge sys_clk_in);
            qual_period_field_in <= seed[31:16];
            qual_case(int'(seed[3:0]), seed[4], {5'h00, seed[7:5]});
        end
        for (int s = 0; s < 4; s++) lp_idle(s);
        for (int d = 0; d < 4; d++) lp_stby(d[1:0], d[0]);
        complete_run();
    end
endmodule

/* iqlp_top.sv */
// Input qualification for 16 pins plus idle and standby wake sequencing.
// Assumes pins, non-maskable, reset and standby wake pins are asynchronous; the rest is
// from logic on sys_clk_in. Clock gating itself is done downstream.
//
// Behaviour
// RULE_01 - Period zero samples every cycle; value n samples every 2n cycles.
// RULE_02 - Period field accepts every value 0 to 0xff.
// RULE_03 - One period field governs each group of eight adjacent pins.
// RULE_04 - Per-pin select chooses three or six samples.
// RULE_05 - Three samples span two sampling periods.
// RULE_06 - Six samples span five sampling periods.
// RULE_07 - Glitches shorter than the window never reach the qualified value.
// RULE_08 - Source holds levels two cycles, or window plus period plus one.
// RULE_09 - Idle wake held two cycles, or five plus window when qualified.
// RULE_10 - Idle leaves on enabled irq, watchdog, non-maskable irq or reset pin.
// RULE_11 - Idle resume within 20 cycles, or 1050 with sleeping flash.
// RULE_12 - Waker waits four oscillator cycles after idle before waking.
// RULE_13 - Standby wake held three cycles, or two plus standby count.
// RULE_14 - External clock goes low 32 to 45 cycles after standby entry.
// RULE_15 - Hold system clock 16, 32 or 64 cycles by divide select.
// RULE_16 - Standby stops peripheral clocks, keeps PLL and watchdog running.
// RULE_17 - Standby resume within 100 cycles, or 1125 with sleeping flash.
// RULE_18 - Software enters standby from RAM with no external bus access.
// RULE_19 - After standby wake, the enabled waking interrupt is serviced.
// RULE_20 - Qualified value changes only when all selected samples agree.
module iqlp_top (
    // Clock and reset
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_n_in,
    // Qualifier pins and control
    input  wire logic [15:0]             pin_in,
    input  wire logic [15:0]             qual_period_field_in,
    input  wire logic [15:0]             qual_select_reg_in,
    output logic      [15:0]             pin_qual_out,
    // Low-power control
    input  wire logic                    idle_exec_in,
    input  wire logic                    lpm_standby_in,
    input  wire logic [1:0]              clock_divide_select_in,
    input  wire logic [5:0]              standby_qual_count_in,
    input  wire logic                    flash_sleep_in,
    // Wake sources
    input  wire logic                    wake_irq_in,
    input  wire logic                    watchdog_interrupt_in,
    input  wire logic                    ext_nonmaskable_irq_in,
    input  wire logic                    device_reset_pin_n_in,
    input  wire logic                    standby_wake_n_in,
    // Clock control and status
    output logic                         sys_clk_en_out,
    output logic                         periph_clk_en_out,
    output logic                         pll_wd_run_out,
    output logic                         external_clock_out,
    output logic                         resume_out,
    output logic                         service_irq_out,
    output logic                         low_power_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    logic [iqlp_pkg::SYNC_W-1:0] sync1_q;
    logic [iqlp_pkg::SYNC_W-1:0] sync2_q;
    logic [iqlp_pkg::NGRP-1:0]   tick_w;
    logic [15:0]                 qual_q;

    // Two-stage synchroniser for every asynchronous input
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sync1_q <= {3'h7, 16'hffff};
            sync2_q <= {3'h7, 16'hffff};
        end else begin
            sync1_q <= {standby_wake_n_in, device_reset_pin_n_in,
                        ~ext_nonmaskable_irq_in, pin_in};
            sync2_q <= sync1_q;
        end
    end

    // Sampling tick per group of eight pins
    for (genvar g = 0; g < iqlp_pkg::NGRP; g++) begin : g_grp
        logic [8:0] per_cnt_q;
        logic [7:0] prd_w;
        logic [8:0] last_w;
        assign prd_w  = qual_period_field_in[g*8 +: 8]; // RULE_03
        assign last_w = {prd_w, 1'b0} - 9'h001;
        // At or past the last count, so a shortened period takes effect at once
        assign tick_w[g] = (prd_w == 8'h00) || (per_cnt_q >= last_w); // RULE_01 RULE_02

        always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in || tick_w[g]) begin
                per_cnt_q <= 9'h000;
            end else begin
                per_cnt_q <= per_cnt_q + 9'h001;
            end
        end

        chk_fast_sample: assert property ((prd_w == 8'h00) |-> tick_w[g]) // RULE_01
            else $error("period zero must sample every cycle");
        chk_slow_sample: assert property ((prd_w == 8'h01 && tick_w[g] && per_cnt_q == 9'h001)
            |=> (prd_w != 8'h01) or (!tick_w[g] ##1 tick_w[g])) // RULE_02
            else $error("period one must sample every two cycles");
    end

    // Per-pin sample history and qualified level
    for (genvar i = 0; i < iqlp_pkg::PINS; i++) begin : g_pin
        logic [5:0] smp_q;
        logic       agree_w;
        assign agree_w = qual_select_reg_in[i]
            ? (&smp_q || ~|smp_q)                    // RULE_06
            : (&smp_q[2:0] || ~|smp_q[2:0]);         // RULE_05

        always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
                smp_q <= iqlp_pkg::SMP_RST;
            end else if (tick_w[i / iqlp_pkg::GROUP]) begin
                smp_q <= {smp_q[4:0], sync2_q[i]};
            end
        end

        // Level accepted only when the chosen depth agrees
        always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
                qual_q[i] <= iqlp_pkg::QUAL_RST;
            end else if (agree_w) begin
                qual_q[i] <= smp_q[0]; // RULE_04 RULE_07 RULE_20
            end
        end

        chk_qual_agree: assert property ($changed(qual_q[i]) |-> $past(agree_w)) // RULE_20
            else $error("qualified level changed without agreement");
        chk_qual_three: assert property ((!qual_select_reg_in[i] && smp_q[2:0] == 3'h7)
            |=> qual_q[i]) // RULE_04
            else $error("three agreeing highs not accepted");
    end
    assign pin_qual_out = qual_q;

    // Low-power sequencing
    iqlp_pkg::iqlp_state_t state_q;
    logic [10:0]           cnt_q;
    logic [10:0]           ent_q;
    logic [10:0]           lat_q;
    logic [6:0]            wk_q;
    logic                  sb_ent_q;
    logic                  irq_wake_q;
    logic [10:0]           hold_w;
    logic [6:0]            need_w;
    logic                  idle_wake_w;
    logic                  sb_wake_w;

    // Hold count by divide select
    always_comb begin
        case (clock_divide_select_in)
            2'h2:    hold_w = iqlp_pkg::HOLD_10;
            2'h3:    hold_w = iqlp_pkg::HOLD_11;
            default: hold_w = iqlp_pkg::HOLD_LO;
        endcase
    end

    assign need_w = (standby_qual_count_in == 6'h00) ? iqlp_pkg::SB_UNQ
                  : iqlp_pkg::SB_QBASE + {1'b0, standby_qual_count_in}; // RULE_13
    assign idle_wake_w = wake_irq_in || watchdog_interrupt_in
                       || !sync2_q[16] || !sync2_q[17]; // RULE_10
    assign sb_wake_w = (wk_q >= need_w) || !sync2_q[17];

    // Standby wake pulse width counter
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || sync2_q[18]) begin
            wk_q <= 7'h00;
        end else if (wk_q != 7'h7f) begin
            wk_q <= wk_q + 7'h01; // RULE_13
        end
    end

    // Cycles since standby entry, for the external clock
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sb_ent_q <= 1'b0;
            ent_q    <= 11'h000;
        end else if (state_q == iqlp_pkg::LP_RUN && idle_exec_in && lpm_standby_in) begin
            sb_ent_q <= 1'b1;
            ent_q    <= 11'h001;
        end else if (state_q == iqlp_pkg::LP_RESUME || state_q == iqlp_pkg::LP_RUN) begin
            sb_ent_q <= 1'b0;
        end else if (ent_q != 11'h7ff) begin
            ent_q <= ent_q + 11'h001;
        end
    end

    // External clock: half rate, parked low once standby settles
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            external_clock_out <= 1'b0;
        end else if (sb_ent_q && ent_q >= iqlp_pkg::XCLK_LOW) begin
            external_clock_out <= 1'b0; // RULE_14
        end else begin
            external_clock_out <= !external_clock_out;
        end
    end

    // Main state machine
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state_q    <= iqlp_pkg::LP_RUN;
            cnt_q      <= 11'h000;
            lat_q      <= iqlp_pkg::IDLE_RES;
            irq_wake_q <= 1'b0;
            resume_out <= 1'b0;
        end else begin
            resume_out <= 1'b0;
            case (state_q)
                iqlp_pkg::LP_RUN: begin
                    cnt_q <= 11'h000;
                    if (idle_exec_in) begin
                        state_q <= lpm_standby_in ? iqlp_pkg::LP_SB_HOLD : iqlp_pkg::LP_IDLE;
                    end
                end
                iqlp_pkg::LP_IDLE: begin
                    if (idle_wake_w) begin
                        state_q    <= iqlp_pkg::LP_RESUME; // RULE_10
                        lat_q      <= flash_sleep_in ? iqlp_pkg::IDLE_RES_SLP
                                                     : iqlp_pkg::IDLE_RES; // RULE_11
                        cnt_q      <= (wake_irq_in || watchdog_interrupt_in)
                                      ? 11'h000 : 11'h002; // Pin wakes lost two in sync
                        irq_wake_q <= wake_irq_in;
                    end
                end
                iqlp_pkg::LP_SB_HOLD: begin
                    cnt_q <= cnt_q + 11'h001;
                    if (cnt_q == hold_w - 11'h001) begin
                        state_q <= iqlp_pkg::LP_SB_SLEEP; // RULE_15
                        cnt_q   <= 11'h000;
                    end
                end
                iqlp_pkg::LP_SB_SLEEP: begin
                    if (sb_wake_w) begin
                        state_q    <= iqlp_pkg::LP_RESUME;
                        lat_q      <= flash_sleep_in ? iqlp_pkg::SB_RES_SLP
                                                     : iqlp_pkg::SB_RES; // RULE_17
                        cnt_q      <= (standby_qual_count_in == 6'h00)
                                      ? {4'h0, iqlp_pkg::SB_UNQ} + 11'h002 : 11'h002; // RULE_17
                        irq_wake_q <= wake_irq_in; // RULE_19
                    end
                end
                iqlp_pkg::LP_RESUME: begin
                    cnt_q <= cnt_q + 11'h001;
                    if (cnt_q == lat_q - 11'h002) begin
                        state_q    <= iqlp_pkg::LP_RUN;
                        resume_out <= 1'b1; // RULE_11 RULE_17
                    end
                end
                default: state_q <= iqlp_pkg::LP_RUN;
            endcase
        end
    end

    // Clock enables and status flops
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sys_clk_en_out    <= 1'b1;
            periph_clk_en_out <= 1'b1;
            pll_wd_run_out    <= 1'b1;
            low_power_out     <= 1'b0;
            service_irq_out   <= 1'b0;
        end else begin
            sys_clk_en_out    <= (state_q != iqlp_pkg::LP_SB_SLEEP);
            periph_clk_en_out <= (state_q != iqlp_pkg::LP_SB_SLEEP); // RULE_16
            pll_wd_run_out    <= 1'b1; // RULE_16
            low_power_out     <= (state_q != iqlp_pkg::LP_RUN);
            service_irq_out   <= (state_q == iqlp_pkg::LP_RESUME)
                && (cnt_q == lat_q - 11'h002) && irq_wake_q; // RULE_19
        end
    end

    sequence s_sb_enter;
        state_q == iqlp_pkg::LP_RUN && idle_exec_in && lpm_standby_in;
    endsequence
    sequence s_hold_done;
        state_q == iqlp_pkg::LP_SB_HOLD && cnt_q == hold_w - 11'h001;
    endsequence

    chk_idle_wake: assert property ((state_q == iqlp_pkg::LP_IDLE && idle_wake_w)
        |=> state_q == iqlp_pkg::LP_RESUME) // RULE_10
        else $error("idle did not leave on wake source");
    chk_hold_gate: assert property (s_hold_done ##1 1'b1 |=> !sys_clk_en_out) // RULE_15
        else $error("system clock not gated after hold count");
    chk_hold_min: assert property (s_sb_enter ##1 1'b1 |-> sys_clk_en_out [*8]) // RULE_15
        else $error("system clock gated too early");
    chk_xclk_low: assert property (s_sb_enter |-> ##45 !external_clock_out
        or ##[1:45] (state_q != iqlp_pkg::LP_SB_HOLD && state_q != iqlp_pkg::LP_SB_SLEEP)) // RULE_14
        else $error("external clock not low by cycle 45");
    chk_sb_clocks: assert property ($past(state_q) == iqlp_pkg::LP_SB_SLEEP
        |-> !periph_clk_en_out && pll_wd_run_out) // RULE_16
        else $error("standby clock states wrong");
    chk_resume_lat: assert property ($rose(resume_out)
        |-> $past(cnt_q) == $past(lat_q) - 11'h002) // RULE_11
        else $error("resume pulse not at programmed latency");
    chk_irq_service: assert property (service_irq_out |-> resume_out) // RULE_19
        else $error("interrupt service without resume");
    chk_sb_wake: assert property ((state_q == iqlp_pkg::LP_SB_SLEEP && wk_q >= need_w)
        |=> state_q == iqlp_pkg::LP_RESUME) // RULE_13
        else $error("standby wake pulse not honoured");
endmodule
